// >>> core/acsp_core.v
// Purpose: Serial control slave, power states and sample coding.
// Assumes: One clock (sample clock, 100 MHz); serial pins are host driven and asynchronous.
// Notes:   Serial pins pass a three-flop filter; samples pass a 32-word FIFO.
// Behaviour
// - Resume conversion 1us after nap, 1ms after sleep
// - Select held low keeps registers alive; 1ms still
// - Data released in nap/sleep; output clock held low, overrange kept
// - Tri-level pin picks power state; register overrides
// - Tri-level pin picks coding; register overrides
// - Offset binary: zeros lowest, ones highest
// - Two's complement inverts only the top bit
// - Gray: top bit kept, others XOR bit above
// - Read data on shared line; bit 7 four-wire
// - Four-wire output driven even when unselected
// - Instruction starts first rising clock after select fall
// - Bit 6 LSB-first; address increments or decrements
// - Instruction: read flag, count bits, 13-bit address
// - Count bits give one, two, three, or streaming
// - Pause allowed short; long transfer aborts on select
// - Setup bit 5 restores port registers to defaults
// - Burst ends when address reaches a nonzero burst stop value
// - Converter select resets zero; unset index reads AD
// - Power field: pin, normal, nap, sleep codes
// - Format field: pin, twos, gray, offset codes
// - Power and format fields survive soft reset
`timescale 1ns/100ps
`include "acsp_map.vh"

// ******
// Sample FIFO
// ******
module acsp_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;

    // Extra pointer bit tells full from empty
    assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty     = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Pointers and storage
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule // acsp_fifo

// ******
// Control port top
// ******
module acsp_core #(
    parameter WIDTH        = 14,
    parameter FIFO_DEPTH   = 32,
    parameter FIFO_AW      = 5,
    parameter NAP_CYCLES   = `ACSP_NAP_REC_CYC,
    parameter SLEEP_CYCLES = `ACSP_SLEEP_REC_CYC,
    parameter [7:0] DIE_ID  = 8'h5a,   // Arbitrary value
    parameter [7:0] DIE_REV = 8'h01    // Arbitrary value
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             sclk,
    input  wire             select_n,
    input  wire             serial_in_line,
    input  wire             bidir_in,
    output wire             bidir_out,
    output wire             bidir_oe,
    output wire             dedicated_serial_out,
    output wire             dedicated_serial_oe,
    input  wire [1:0]       power_state_pin,
    input  wire [1:0]       format_select_pin,
    input  wire [WIDTH-1:0] sample_in,
    input  wire             sample_valid,
    output wire             sample_ready,
    output reg  [WIDTH-1:0] data_out,
    output reg              data_valid,
    input  wire             data_ready,
    output wire             data_oe,
    output reg              output_clock,
    output reg              overrange_flag,
    output wire             conversion_live
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_INSTR = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam PW_NORMAL = 2'd0;
    localparam PW_NAP    = 2'd1;
    localparam PW_SLEEP  = 2'd2;
    localparam NS = 8;

    // ******
    // Input filter: three flops, last two agree
    // ******
    wire [NS-1:0] raw_in;
    reg  [NS-1:0] sync1;
    reg  [NS-1:0] sync2;
    reg  [NS-1:0] sync3;
    reg  [NS-1:0] filt;
    reg           sclk_prev;
    reg           sel_prev;
    assign raw_in = {format_select_pin, power_state_pin, bidir_in, serial_in_line, select_n, sclk};

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
            // Reset high so select_n starts deselected
            always @(posedge clk) begin
                if (rst) begin
                    sync1[gi] <= (gi == 1);
                    sync2[gi] <= (gi == 1);
                    sync3[gi] <= (gi == 1);
                    filt[gi]  <= (gi == 1);
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        filt[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    wire       f_sclk   = filt[0];
    wire       f_sel    = filt[1];
    wire       f_sdi    = filt[2];
    wire       f_bidir  = filt[3];
    wire [1:0] f_pw_pin = filt[5:4];
    wire [1:0] f_fm_pin = filt[7:6];

    // Edge markers
    always @(posedge clk) begin
        if (rst) begin
            sclk_prev <= 1'b0;
            sel_prev  <= 1'b1;
        end else begin
            sclk_prev <= f_sclk;
            sel_prev  <= f_sel;
        end
    end
    wire sclk_rise = f_sclk && !sclk_prev && !f_sel;
    wire sel_fall  = !f_sel && sel_prev;
    wire sel_rise  = f_sel && !sel_prev;

    // ******
    // Register file
    // ******
    reg       four_wire;
    reg       lsb_first;
    reg [7:0] burst_stop_address;
    reg [7:0] converter_select;
    reg [2:0] power_sel;
    reg [2:0] format_sel;
    reg        wr_stb;
    reg [12:0] wr_addr;
    reg [7:0]  wr_data;

    // Read mux shared by instruction and byte-advance paths
    function [7:0] rd_mux;
        input [12:0] a;
        begin
            case (a)
                `ACSP_ADDR_SETUP:
                    rd_mux = {four_wire, lsb_first, 1'b0, 1'b1, 1'b1, 1'b0, lsb_first, four_wire};
                `ACSP_ADDR_BURST:    rd_mux = burst_stop_address;
                `ACSP_ADDR_DIE_ID:   rd_mux = DIE_ID;
                `ACSP_ADDR_DIE_REV:  rd_mux = DIE_REV;
                `ACSP_ADDR_CONV_SEL: rd_mux = converter_select;
                `ACSP_ADDR_MODES:
                    rd_mux = (converter_select == 8'h00) ? `ACSP_NO_INDEX_BYTE : {5'h00, power_sel};
                `ACSP_ADDR_OUT_MODE:
                    rd_mux = (converter_select == 8'h00) ? `ACSP_NO_INDEX_BYTE : {5'h00, format_sel};
                default:             rd_mux = `ACSP_UNMAPPED_BYTE;
            endcase
        end
    endfunction

    // Writes; soft reset leaves power and format fields alone
    always @(posedge clk) begin
        if (rst) begin
            four_wire          <= 1'b0;
            lsb_first          <= 1'b0;
            burst_stop_address <= `ACSP_BURST_RST;
            converter_select   <= `ACSP_CONV_SEL_RST;
            power_sel          <= `ACSP_SEL_RST;
            format_sel         <= `ACSP_SEL_RST;
        end else if (wr_stb) begin
            case (wr_addr)
                `ACSP_ADDR_SETUP: begin
                    if (wr_data[`ACSP_SETUP_SOFT_RST]) begin
                        four_wire          <= 1'b0;
                        lsb_first          <= 1'b0;
                        burst_stop_address <= `ACSP_BURST_RST;
                        converter_select   <= `ACSP_CONV_SEL_RST;
                    end else begin
                        four_wire <= wr_data[`ACSP_SETUP_FOUR_WIRE];
                        lsb_first <= wr_data[`ACSP_SETUP_LSB_FIRST];
                    end
                end
                `ACSP_ADDR_BURST:    burst_stop_address <= wr_data;
                `ACSP_ADDR_CONV_SEL: converter_select   <= wr_data;
                // Indexed: only converter 0 exists in this block
                `ACSP_ADDR_MODES:
                    if (converter_select[0])
                        power_sel <= wr_data[2:0];
                `ACSP_ADDR_OUT_MODE:
                    if (converter_select[0])
                        format_sel <= wr_data[2:0];
                default: ;
            endcase
        end
    end

    // ******
    // Serial port state machine
    // ******
    reg [1:0]  state;
    reg [3:0]  bit_cnt;
    reg [15:0] instr_sh;
    reg [7:0]  byte_sh;
    reg [7:0]  rd_sh;
    reg        is_read;
    reg [1:0]  count_code;
    reg [12:0] addr;
    reg [1:0]  bytes_done;
    wire       in_bit = four_wire ? f_sdi : f_bidir;
    wire [15:0] next_instr = lsb_first ? {in_bit, instr_sh[15:1]} : {instr_sh[14:0], in_bit};
    wire [7:0]  next_byte  = lsb_first ? {in_bit, byte_sh[7:1]} : {byte_sh[6:0], in_bit};
    wire [12:0] next_addr  = lsb_first ? addr - 13'h0001 : addr + 13'h0001;
    wire       streaming  = (count_code == 2'b11);
    wire       last_byte  = streaming ? ((burst_stop_address != 8'h00) && (addr[7:0] == burst_stop_address))
                                      : (bytes_done == count_code);

    // Shifting on filtered serial clock rising edges
    always @(posedge clk) begin
        if (rst) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            instr_sh   <= 16'h0000;
            byte_sh    <= 8'h00;
            rd_sh      <= 8'h00;
            is_read    <= 1'b0;
            count_code <= 2'b00;
            addr       <= 13'h0000;
            bytes_done <= 2'b00;
            wr_stb     <= 1'b0;
            wr_addr    <= 13'h0000;
            wr_data    <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (sel_rise && state == ST_DATA && streaming && (bit_cnt != 4'h0 || bytes_done != 2'b00)) begin
                state <= ST_IDLE;
            end else if (sel_fall && state == ST_IDLE) begin
                state   <= ST_INSTR;
                bit_cnt <= 4'h0;
            end else if (sclk_rise) begin
                case (state)
                    ST_INSTR: begin
                        instr_sh <= next_instr;
                        bit_cnt  <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'hf) begin
                            is_read    <= next_instr[15];
                            count_code <= next_instr[14:13];
                            addr       <= next_instr[12:0];
                            rd_sh      <= rd_mux(next_instr[12:0]);
                            bytes_done <= 2'b00;
                            bit_cnt    <= 4'h0;
                            state      <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        byte_sh <= next_byte;
                        rd_sh   <= lsb_first ? {1'b0, rd_sh[7:1]} : {rd_sh[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            bit_cnt <= 4'h0;
                            wr_stb  <= !is_read;
                            wr_addr <= addr;
                            wr_data <= next_byte;
                            if (bytes_done != 2'b11)
                                bytes_done <= bytes_done + 2'b01;
                            addr  <= next_addr;
                            rd_sh <= rd_mux(next_addr);
                            if (last_byte)
                                state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Serial output pins
    wire ser_bit = lsb_first ? rd_sh[0] : rd_sh[7];
    assign bidir_out            = ser_bit;
    assign bidir_oe             = !four_wire && !f_sel && state == ST_DATA && is_read;
    assign dedicated_serial_out = ser_bit;
    assign dedicated_serial_oe  = four_wire;

    // ******
    // Power state and recovery
    // ******
    reg [1:0]  pw_mode;
    reg [1:0]  pw_prev;
    reg [19:0] rec_cnt;

    always @* begin
        case (power_sel)
            `ACSP_SEL_A: pw_mode = PW_NORMAL;
            `ACSP_SEL_B: pw_mode = PW_NAP;
            `ACSP_SEL_C: pw_mode = PW_SLEEP;
            default: begin
                case (f_pw_pin)
                    `ACSP_PIN_LOW:   pw_mode = PW_NORMAL;
                    `ACSP_PIN_FLOAT: pw_mode = PW_SLEEP;
                    default:         pw_mode = PW_NAP;
                endcase
            end
        endcase
    end

    // Recovery wait armed by the exit from a low-power state
    always @(posedge clk) begin
        if (rst) begin
            pw_prev <= PW_NORMAL;
            rec_cnt <= 20'h00000;
        end else begin
            pw_prev <= pw_mode;
            if (pw_mode != PW_NORMAL)
                rec_cnt <= 20'h00000;
            else if (pw_prev == PW_NAP)
                rec_cnt <= NAP_CYCLES[19:0];
            else if (pw_prev == PW_SLEEP)
                rec_cnt <= SLEEP_CYCLES[19:0];
            else if (rec_cnt != 20'h00000)
                rec_cnt <= rec_cnt - 20'h00001;
        end
    end
    assign conversion_live = (pw_mode == PW_NORMAL) && (pw_prev == PW_NORMAL) && (rec_cnt == 20'h00000);

    // ******
    // Sample coding
    // ******
    reg [1:0] fmt_mode;
    always @* begin
        case (format_sel)
            `ACSP_SEL_A: fmt_mode = 2'd1;
            `ACSP_SEL_B: fmt_mode = 2'd2;
            `ACSP_SEL_C: fmt_mode = 2'd0;
            default: begin
                case (f_fm_pin)
                    `ACSP_PIN_LOW:   fmt_mode = 2'd0;
                    `ACSP_PIN_FLOAT: fmt_mode = 2'd1;
                    default:         fmt_mode = 2'd2;
                endcase
            end
        endcase
    end

    // 0 offset binary, 1 two's complement, 2 Gray
    function [WIDTH-1:0] encode;
        input [1:0]       m;
        input [WIDTH-1:0] b;
        begin
            case (m)
                2'd1:    encode = {~b[WIDTH-1], b[WIDTH-2:0]};
                2'd2:    encode = b ^ (b >> 1);
                default: encode = b;
            endcase
        end
    endfunction

    // ******
    // Sample path: FIFO then output stage
    // ******
    wire [WIDTH-1:0] fifo_data;
    wire             fifo_valid;
    wire             fifo_in_ready;
    wire             stage_load = fifo_valid && (!data_valid || data_ready);

    // Samples refused until conversion has resumed
    assign sample_ready = fifo_in_ready && conversion_live;

    acsp_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (sample_in),
        .in_valid  (sample_valid && conversion_live),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (stage_load)
    );

    // Output stage; coding applied as each word leaves the FIFO
    always @(posedge clk) begin
        if (rst) begin
            data_out       <= {WIDTH{1'b0}};
            data_valid     <= 1'b0;
            overrange_flag <= 1'b0;
            output_clock   <= 1'b0;
        end else begin
            output_clock <= (pw_mode == PW_NORMAL) ? ~output_clock : 1'b0;
            if (stage_load) begin
                data_out       <= encode(fmt_mode, fifo_data);
                overrange_flag <= &fifo_data; // Positive full scale
                data_valid     <= 1'b1;
            end else if (data_ready) begin
                data_valid <= 1'b0;
            end
        end
    end

    // Released pins in nap or sleep
    assign data_oe = (pw_mode == PW_NORMAL);
endmodule // acsp_core

// >>> core/acsp_map.vh
// Purpose: Offsets, fields, resets and timing counts of the control port.
// Assumes: Included by core/acsp_core.v only.
// Notes:   Definitions only.
`ifndef ACSP_MAP_VH
`define ACSP_MAP_VH

// ******
// Register offsets
// ******
`define ACSP_ADDR_SETUP      13'h0000
`define ACSP_ADDR_BURST      13'h0002
`define ACSP_ADDR_DIE_ID     13'h0008
`define ACSP_ADDR_DIE_REV    13'h0009
`define ACSP_ADDR_CONV_SEL   13'h0010
`define ACSP_ADDR_MODES      13'h0025
`define ACSP_ADDR_OUT_MODE   13'h0073

// ******
// Fields and reset values
// ******
`define ACSP_SETUP_FOUR_WIRE 7
`define ACSP_SETUP_LSB_FIRST 6
`define ACSP_SETUP_SOFT_RST  5
`define ACSP_BURST_RST       8'h00
`define ACSP_CONV_SEL_RST    8'h00
`define ACSP_SEL_RST         3'h0
`define ACSP_NO_INDEX_BYTE   8'had
`define ACSP_UNMAPPED_BYTE   8'h00

// Three-bit selection codes
`define ACSP_SEL_PIN         3'h0
`define ACSP_SEL_A           3'h1
`define ACSP_SEL_B           3'h2
`define ACSP_SEL_C           3'h4

// Tri-level pin codes
`define ACSP_PIN_LOW         2'h0
`define ACSP_PIN_FLOAT       2'h1
`define ACSP_PIN_HIGH        2'h2

// ******
// Timing in ns and clocks
// ******
`define ACSP_CLK_PERIOD_NS   10
`define ACSP_NAP_REC_NS      1000
`define ACSP_SLEEP_REC_NS    1000000
`define ACSP_NAP_REC_CYC     ((`ACSP_NAP_REC_NS + `ACSP_CLK_PERIOD_NS - 1) / `ACSP_CLK_PERIOD_NS)
`define ACSP_SLEEP_REC_CYC   ((`ACSP_SLEEP_REC_NS + `ACSP_CLK_PERIOD_NS - 1) / `ACSP_CLK_PERIOD_NS)

`endif

// >>> dv/acsp_core_chk.sv
// Purpose: Checks on the control port pins.
// Assumes: One clock domain; recovery counts of at least 8 clocks.
// Notes:   Bound to every acsp_core instance.
`timescale 1ns/100ps
module acsp_core_chk #(
    parameter WIDTH = 14
) (
    input wire             clk,
    input wire             rst,
    input wire             select_n,
    input wire             bidir_oe,
    input wire             dedicated_serial_oe,
    input wire             data_oe,
    input wire             output_clock,
    input wire             data_valid,
    input wire             data_ready,
    input wire [WIDTH-1:0] data_out,
    input wire             sample_ready,
    input wire             conversion_live
);
    // ******
    // Sequences and properties
    // ******
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Outlasts the pin filter
    sequence s_deselected;
        select_n [*6];
    endsequence
    // Three normal clocks
    sequence s_running;
        data_oe [*3];
    endsequence
    chk_lines_exclusive: assert property (dedicated_serial_oe |-> !bidir_oe)
        else $error("shared and dedicated lines driven together");
    chk_idle_release: assert property (s_deselected |-> !bidir_oe)
        else $error("shared line driven while deselected");
    chk_low_power_quiet: assert property (!data_oe [*2] |-> !output_clock)
        else $error("output clock active in low power");
    chk_live_normal: assert property (conversion_live |-> data_oe)
        else $error("conversion live outside normal mode");
    chk_ready_live: assert property (sample_ready |-> conversion_live)
        else $error("samples taken before recovery");
    chk_wake_delay: assert property ($rose(data_oe) |-> !conversion_live [*8])
        else $error("recovery shorter than expected");
    chk_clock_toggle: assert property (s_running |-> output_clock != $past(output_clock))
        else $error("output clock stuck in normal mode");
    chk_data_hold: assert property (data_valid && !data_ready |=> !data_oe || (data_valid && $stable(data_out)))
        else $error("output word dropped under back-pressure");
endmodule // acsp_core_chk

bind acsp_core acsp_core_chk #(.WIDTH(WIDTH)) u_chk (.clk, .rst, .select_n, .bidir_oe, .dedicated_serial_oe,
    .data_oe, .output_clock, .data_valid, .data_ready, .data_out, .sample_ready, .conversion_live);

// >>> dv/acsp_host.sv
// Purpose: Behavioural serial host for the converter control port.
// Assumes: Bench calls xfer; lsb selects bit order of the whole frame.
// Notes:   Half period of 34 clocks keeps reads under the rate cap.
`timescale 1ns/100ps
module acsp_host (
    input  wire  clk,
    input  wire  sdio,
    output logic sclk,
    output logic select_n,
    output logic mosi,
    output logic mosi_en
);
    logic [7:0] wbuf [0:7];
    logic [7:0] rbuf [0:7];
    logic       lsb = 1'b0;
    // Idle: clock low, deselected, line released
    initial {sclk, select_n, mosi, mosi_en} = 4'b0100;
    // One bit: data set with clock low, read at the rise
    task automatic bit_io(input logic d, output logic q);
        mosi <= d;
        repeat (34) @(posedge clk);
        sclk <= 1'b1;
        q = sdio;
        repeat (34) @(posedge clk);
        sclk <= 1'b0;
    endtask
    // Whole frame; select released only at the end
    task automatic xfer(input logic rd, input logic [1:0] wc, input logic [12:0] a, input int n);
        logic [15:0] ins;
        logic [7:0]  b;
        logic        q;
        ins = {rd, wc, a};
        @(posedge clk);
        select_n <= 1'b0;
        mosi_en  <= 1'b1;
        for (int i = 0; i < 16; i++) bit_io(ins[lsb ? i : 15-i], q);
        mosi_en <= !rd;
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                bit_io(!rd && wbuf[k][lsb ? i : 7-i], q);
                b[lsb ? i : 7-i] = q;
            end
            rbuf[k] = b;
        end
        repeat (10) @(posedge clk);
        select_n <= 1'b1;
        mosi_en  <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
endmodule // acsp_host

// >>> dv/acsp_core_tb.sv
// Purpose: Self-checking bench for the converter control port.
// Assumes: Recovery counts shortened to 10 and 200 clocks.
// Notes:   Streaming abort shows in the next frame.
`timescale 1ns/100ps
module acsp_core_tb;
    logic        clk = 1'b0, rst = 1'b1, last = 1'b0;
    logic        sclk, select_n, serial_in_line, mosi_en, sample_valid, data_ready;
    logic        bidir_out, bidir_oe, dedicated_serial_out, dedicated_serial_oe, sample_ready;
    logic        data_valid, data_oe, output_clock, overrange_flag, conversion_live;
    logic [1:0]  power_state_pin, format_select_pin;
    logic [13:0] sample_in, data_out;
    int          n_mismatch = 0, n_tests = 0;
    wire         bidir_in = bidir_oe ? bidir_out : (mosi_en ? serial_in_line : ~last);
    wire         h_in = dedicated_serial_oe ? dedicated_serial_out : bidir_in;
    // ******
    // Clock and parts
    // ******
    always #5 clk = ~clk;
    // Released shared line wanders instead of holding its last bit
    always @(posedge clk) last <= bidir_in;
    acsp_core #(.NAP_CYCLES(10), .SLEEP_CYCLES(200), .DIE_ID(8'h3c), .DIE_REV(8'h07)) u_dut ( // Arbitrary ids
        .clk, .rst, .sclk, .select_n, .serial_in_line, .bidir_in, .bidir_out, .bidir_oe,
        .dedicated_serial_out, .dedicated_serial_oe, .power_state_pin, .format_select_pin,
        .sample_in, .sample_valid, .sample_ready, .data_out, .data_valid, .data_ready,
        .data_oe, .output_clock, .overrange_flag, .conversion_live);
    acsp_host u_host (.clk, .sdio(h_in), .sclk, .select_n, .mosi(serial_in_line), .mosi_en);
    // ******
    // Helpers
    // ******
    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        u_host.wbuf[0] = d;
        u_host.xfer(1'b0, 2'b00, a, 1);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        u_host.xfer(1'b1, 2'b00, a, 1);
        chk(u_host.rbuf[0], e);
    endtask
    function automatic logic [13:0] enc(input logic [13:0] v, input int f);
        return f == 1 ? {~v[13], v[12:0]} : (f == 2 ? v ^ (v >> 1) : v);
    endfunction
    // One sample through the path, coded word compared
    task automatic push(input logic [13:0] v, input int f);
        sample_in    <= v;
        sample_valid <= 1'b1;
        for (int i = 0; i < 99; i++) begin
            @(posedge clk);
            if (sample_ready === 1'b1) break;
        end
        sample_valid <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            if (data_valid === 1'b1) break;
        end
        chk({overrange_flag, data_out}, {&v, enc(v, f)});
    endtask
    // ******
    // Scenarios
    // ******
    task automatic t_regs;
        rd(13'h0000, 8'h18);
        rd(13'h0010, 8'h00);
        rd(13'h0025, 8'had);
        rd(13'h0005, 8'h00);
        wr(13'h0008, 8'hff);
        rd(13'h0008, 8'h3c);
        u_host.xfer(1'b1, 2'b11, 13'h0007, 4);
        chk({u_host.rbuf[0], u_host.rbuf[1], u_host.rbuf[2], u_host.rbuf[3]}, 32'h003c0700);
        u_host.xfer(1'b1, 2'b10, 13'h0008, 3);
        chk({u_host.rbuf[1], u_host.rbuf[2]}, 16'h0700);
        wr(13'h0002, 8'h0f);
        u_host.wbuf[1] = 8'h55;
        u_host.xfer(1'b0, 2'b11, 13'h000f, 2);
        rd(13'h0010, 8'h00);
    endtask
    // Fill against a stalled reader, then drain in order
    task automatic t_fifo;
        int n = 0;
        int k = 0;
        data_ready   <= 1'b0;
        sample_in    <= 14'h0000;
        sample_valid <= 1'b1;
        repeat (60) begin
            @(posedge clk);
            if (sample_ready === 1'b1) begin
                n++;
                sample_in <= 14'(n);
            end
        end
        sample_valid <= 1'b0;
        chk(n >= 32, 1'b1);
        data_ready <= 1'b1;
        repeat (80) begin
            @(posedge clk);
            if (data_valid === 1'b1) begin
                chk(data_out, 14'(k));
                k++;
            end
        end
        chk(k, n);
    endtask
    // Pin codings, then register codes over a Gray pin
    task automatic t_format;
        int codes[6] = '{0, 1, 2, 1, 2, 4};
        int fmts[6] = '{0, 1, 2, 1, 2, 0};
        for (int c = 0; c < 6; c++) begin
            if (c < 3) format_select_pin <= 2'(c);
            else wr(13'h0073, 8'(codes[c]));
            if (c == 2) wr(13'h0010, 8'h01);
            repeat (8) @(posedge clk);
            push(14'h0000, fmts[c]);
            push(14'h3fff, fmts[c]);
            push(14'h2000, fmts[c]);
            push(14'h1235, fmts[c]);
        end
    endtask
    task automatic t_power;
        wr(13'h0025, 8'h02);
        chk({data_oe, output_clock, sample_ready}, 3'b000);
        wr(13'h0025, 8'h01);
        chk(conversion_live, 1'b1);
        wr(13'h0025, 8'h04);
        chk(data_oe, 1'b0);
        wr(13'h0025, 8'h01);
        chk(conversion_live, 1'b0);
        repeat (160) @(posedge clk);
        chk(conversion_live, 1'b1);
        wr(13'h0025, 8'h00);
        power_state_pin <= 2'h1;
        repeat (8) @(posedge clk);
        chk(data_oe, 1'b0);
        power_state_pin <= 2'h2;
        wr(13'h0025, 8'h01);
        chk(data_oe, 1'b1);
        wr(13'h0025, 8'h00);
        chk(data_oe, 1'b0);
        power_state_pin <= 2'h0;
        repeat (250) @(posedge clk);
        chk(conversion_live, 1'b1);
    endtask
    // Mirrored setup values read alike in both orders
    task automatic t_port;
        wr(13'h0000, 8'hdb);
        chk(dedicated_serial_oe, 1'b1);
        u_host.lsb = 1'b1;
        rd(13'h0000, 8'hdb);
        u_host.xfer(1'b1, 2'b01, 13'h0009, 2);
        chk({u_host.rbuf[0], u_host.rbuf[1]}, 16'h073c);
        wr(13'h0000, 8'h3c);
        u_host.lsb = 1'b0;
        chk(dedicated_serial_oe, 1'b0);
        rd(13'h0025, 8'had);
        rd(13'h0002, 8'h00);
        wr(13'h0010, 8'h01);
        rd(13'h0073, 8'h04);
    endtask
    // ******
    // Sequence, verdict and watchdog
    // ******
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #900_000;
        n_mismatch++;
        end_of_test;
    end
    // Clock runs through low power
    initial begin
        sample_in = 14'h0000;
        sample_valid = 1'b0;
        data_ready = 1'b1;
        power_state_pin = 2'h0;
        format_select_pin = 2'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_regs;
        t_fifo;
        t_format;
        t_power;
        t_port;
        end_of_test;
    end
endmodule // acsp_core_tb
